// *** irq_defines.svh ***
// register map, field layout, reset values and fixed counts of the interrupt register bank
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 32
`define STRB_W 4

`define OFS_ENABLE_7 8'h00
`define OFS_PRIORITY_0 8'h04
`define OFS_PRIORITY_1 8'h08
`define OFS_PRIORITY_2 8'h0c
`define OFS_PRIORITY_3 8'h10
`define OFS_PRIORITY_4 8'h14
`define OFS_SRC_ENABLE 8'h18
`define OFS_DEBUG_PRIORITY 8'h1c
`define OFS_STATUS 8'h20
`define OFS_MASK 8'h24
`define OFS_ACTIVE 8'h28

`define DEBUG_EN_BIT 5
`define PRIO_W 3
`define PRIO_RESET 3'h4
`define PRIO_OFF 3'h0
`define PRIO_REGS 5
`define PRIO_SLOTS_PER_REG 4
`define PRIO_SLOT_STRIDE 4
`define PRIO_TOP_LSB 12
`define PRIO_REG_STRIDE 4

`define SRC_NUM 21
`define SRC_ID_W 5
`define DEBUG_SLOT 20
`define EMPTY_SLOT 12
`define SRC_EN_W 20
`define SRC_EN_MASK 20'hfefff
`define SRC_IMPL_MASK 21'h1fefff
`define SRC_EN_RESET 20'h00000
`define STATUS_RESET 21'h000000
`define MASK_RESET 21'h000000

`define ACTIVE_ID_LSB 8
`define ACTIVE_IRQ_BIT 15

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** irq_pkg.sv ***
// shared types of the interrupt enable and priority register bank
`include "irq_defines.svh"

package irq_pkg;
  typedef logic [`PRIO_W-1:0] prio_t;
  typedef logic [`SRC_NUM-1:0] src_vec_t;
  typedef logic [`SRC_ID_W-1:0] src_id_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`STRB_W-1:0] strb_t;
endpackage

// *** prio_field_reg.sv ***
// one three-bit software-written priority field
`timescale 1ns/1ps
`include "irq_defines.svh"

module prio_field_reg
  import irq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire prio_t wdata_i,
  output prio_t prio_o
);

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prio_o <= `PRIO_RESET;
    end
    else if (we_i)
    begin
      prio_o <= wdata_i;
    end
  end

endmodule

// *** irq_axil_port.sv ***
// axi4-lite slave front end: one write and one read in flight, user-side strobes
`timescale 1ns/1ps
`include "irq_defines.svh"

module irq_axil_port
  import irq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire addr_t awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire data_t wdata_i,
  input wire strb_t wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire addr_t araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output data_t rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_en_o,
  output addr_t wr_addr_o,
  output data_t wr_data_o,
  output strb_t wr_strb_o,
  input wire logic wr_err_i,
  output logic rd_en_o,
  output addr_t rd_addr_o,
  input wire data_t rd_data_i,
  input wire logic rd_err_i
);

  // ready low means the channel holds a taken beat
  assign wr_en_o = !awready_o && !wready_o && !bvalid_o;
  assign rd_en_o = !arready_o && !rvalid_o;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      awready_o <= 1'b1;
      wr_addr_o <= '0;
    end
    else if (awvalid_i && awready_o)
    begin
      awready_o <= 1'b0;
      wr_addr_o <= awaddr_i;
    end
    else if (wr_en_o)
    begin
      awready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wready_o <= 1'b1;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end
    else if (wvalid_i && wready_o)
    begin
      wready_o <= 1'b0;
      wr_data_o <= wdata_i;
      wr_strb_o <= wstrb_i;
    end
    else if (wr_en_o)
    begin
      wready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bvalid_o <= 1'b0;
      bresp_o <= `RESP_OKAY;
    end
    else if (wr_en_o)
    begin
      bvalid_o <= 1'b1;
      bresp_o <= wr_err_i ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (bready_i)
    begin
      bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      arready_o <= 1'b1;
      rd_addr_o <= '0;
    end
    else if (arvalid_i && arready_o)
    begin
      arready_o <= 1'b0;
      rd_addr_o <= araddr_i;
    end
    else if (rvalid_o && rready_i)
    begin
      arready_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= `RESP_OKAY;
    end
    else if (rd_en_o)
    begin
      rvalid_o <= 1'b1;
      rdata_o <= rd_data_i;
      rresp_o <= rd_err_i ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rready_i)
    begin
      rvalid_o <= 1'b0;
    end
  end

endmodule

// *** irq_enable_priority_regs.sv ***
// interrupt enable and priority register bank with request gating and arbitration
// Notes on behaviour
// R1: enable bit one passes request, zero blocks
// R2: unimplemented bits ignore writes, read zero
// R3: enable register seven holds only bit 5
// R4: three-bit field, code 111 is level 7
// R5: code 001 is level 1, others linear
// R6: code 000 disables source regardless of enable
// R7: priority fields reset to 100, enables to 0
// R8: priority 0: timer1, compare1, capture1, ext0
// R9: priority 1: timer2, compare2, capture2, dma0
// R10: priority 2: uart1 rx, spi1 tx, spi1, timer3
// R11: priority 3: bits 15-11 empty; dma1, adc1, uart1 tx
// R12: priority 4: change notify, comparator, i2c1 master/slave
// R13: separator bits 15, 11, 7, 3 read zero
// R14: forward enabled nonzero sources; highest level wins
`timescale 1ns/1ps
`include "irq_defines.svh"

module irq_enable_priority_regs
  import irq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire addr_t awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire data_t wdata_i,
  input wire strb_t wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire addr_t araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output data_t rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire src_vec_t src_req_i,
  output logic irq_o,
  output prio_t irq_level_o,
  output src_id_t irq_id_o
);

  logic wr_en;
  addr_t wr_addr;
  data_t wr_data;
  strb_t wr_strb;
  logic wr_err;
  logic rd_en;
  addr_t rd_addr;
  data_t rd_data;
  logic rd_err;
  data_t wmask;

  logic debug_port_irq_enable_ff;
  logic [`SRC_EN_W-1:0] src_enable_ff;
  src_vec_t status_ff;
  src_vec_t mask_ff;
  prio_t prio [`SRC_NUM];
  logic [15:0] prio_word [`PRIO_REGS];

  src_vec_t enable_vec;
  src_vec_t prio_live;
  src_vec_t forward;
  src_vec_t pending;
  src_vec_t status_clr;
  src_vec_t nxt_status;
  prio_t nxt_level;
  src_id_t nxt_id;

  irq_axil_port u_port (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(wr_err),
    .rd_en_o(rd_en),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  function automatic logic addr_mapped(input addr_t a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      `OFS_ENABLE_7, `OFS_PRIORITY_0, `OFS_PRIORITY_1, `OFS_PRIORITY_2,
      `OFS_PRIORITY_3, `OFS_PRIORITY_4, `OFS_SRC_ENABLE, `OFS_DEBUG_PRIORITY,
      `OFS_STATUS, `OFS_MASK, `OFS_ACTIVE:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // unmapped addresses answer slverr and change nothing
  assign wr_err = !addr_mapped(wr_addr);
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // R3: only the debug port enable is kept
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // R7: enables clear at reset
      debug_port_irq_enable_ff <= 1'b0;
    end
    else if (wr_en && wr_addr == `OFS_ENABLE_7 && wr_strb[0])
    begin
      debug_port_irq_enable_ff <= wr_data[`DEBUG_EN_BIT];
    end
  end

  // R2: empty slot and upper bits never store
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      src_enable_ff <= `SRC_EN_RESET;
    end
    else if (wr_en && wr_addr == `OFS_SRC_ENABLE)
    begin
      src_enable_ff <= (src_enable_ff & ~wmask[`SRC_EN_W-1:0])
        | (wr_data[`SRC_EN_W-1:0] & wmask[`SRC_EN_W-1:0] & `SRC_EN_MASK);
    end
  end

  // a one lets the latched bit reach the pin
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mask_ff <= `MASK_RESET;
    end
    else if (wr_en && wr_addr == `OFS_MASK)
    begin
      mask_ff <= (mask_ff & ~wmask[`SRC_NUM-1:0])
        | (wr_data[`SRC_NUM-1:0] & wmask[`SRC_NUM-1:0] & `SRC_IMPL_MASK);
    end
  end

  // one field per slot; slot 12 is the gap at the top of priority register 3
  for (genvar s = 0; s < `SRC_NUM; s++)
  begin : g_slot
    if (s == `EMPTY_SLOT)
    begin : g_gap
      // R11: upper field of register 3 absent
      assign prio[s] = `PRIO_OFF;
    end
    else
    begin : g_field
      localparam int REG_IDX = s / `PRIO_SLOTS_PER_REG;
      localparam int LSB = (s == `DEBUG_SLOT) ? 0 :
        `PRIO_TOP_LSB - `PRIO_SLOT_STRIDE * (s % `PRIO_SLOTS_PER_REG);
      localparam addr_t FIELD_ADDR = (s == `DEBUG_SLOT) ? `OFS_DEBUG_PRIORITY :
        `ADDR_W'(`OFS_PRIORITY_0 + `PRIO_REG_STRIDE * REG_IDX);
      logic field_we;
      // R8: R9: R10: R11: R12: field placement
      assign field_we = wr_en && wr_addr == FIELD_ADDR && wr_strb[LSB / 8];
      // R4: R5: R7: three bits, reset 100
      prio_field_reg u_field (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .we_i(field_we),
        .wdata_i(wr_data[LSB +: `PRIO_W]),
        .prio_o(prio[s])
      );
    end
  end

  // R13: separator bits stay zero in every packed word
  always_comb
  begin
    for (int r = 0; r < `PRIO_REGS; r++)
    begin
      prio_word[r] = 16'h0000;
      for (int k = 0; k < `PRIO_SLOTS_PER_REG; k++)
      begin
        prio_word[r][`PRIO_TOP_LSB - `PRIO_SLOT_STRIDE * k +: `PRIO_W] =
          prio[r * `PRIO_SLOTS_PER_REG + k];
      end
    end
  end

  // R6: code 000 silences source
  always_comb
  begin
    for (int i = 0; i < `SRC_NUM; i++)
    begin
      prio_live[i] = prio[i] != `PRIO_OFF;
    end
  end

  // R1: R14: enable and nonzero level both needed
  always_comb
  begin
    enable_vec = {debug_port_irq_enable_ff, src_enable_ff};
    forward = src_req_i & enable_vec & prio_live & `SRC_IMPL_MASK;
  end

  // a request in the clearing cycle stays set
  always_comb
  begin
    status_clr = '0;
    if (wr_en && wr_addr == `OFS_STATUS)
    begin
      status_clr = wr_data[`SRC_NUM-1:0] & wmask[`SRC_NUM-1:0];
    end
    nxt_status = (status_ff & ~status_clr) | forward;
  end

  // sticky until software writes a one
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_ff <= `STATUS_RESET;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  // R6: a field set to 000 later also silences its latched status
  assign pending = status_ff & mask_ff & prio_live;

  // R14: strict compare, so ties go to the lowest slot
  always_comb
  begin
    nxt_level = `PRIO_OFF;
    nxt_id = '0;
    for (int i = 0; i < `SRC_NUM; i++)
    begin
      if (pending[i] && prio[i] > nxt_level)
      begin
        nxt_level = prio[i];
        nxt_id = `SRC_ID_W'(i);
      end
    end
  end

  // registered so the pin never glitches while fields change
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |pending;
    end
  end

  // R14: winning level
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_level_o <= `PRIO_OFF;
    end
    else
    begin
      irq_level_o <= nxt_level;
    end
  end

  // R14: winning source index
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_id_o <= '0;
    end
    else
    begin
      irq_id_o <= nxt_id;
    end
  end

  // R2: unimplemented bits read zero
  always_comb
  begin
    rd_data = '0;
    rd_err = 1'b0;
    unique case (rd_addr)
      `OFS_ENABLE_7:
        rd_data[`DEBUG_EN_BIT] = debug_port_irq_enable_ff;
      `OFS_PRIORITY_0:
        rd_data[15:0] = prio_word[0];
      `OFS_PRIORITY_1:
        rd_data[15:0] = prio_word[1];
      `OFS_PRIORITY_2:
        rd_data[15:0] = prio_word[2];
      `OFS_PRIORITY_3:
        rd_data[15:0] = prio_word[3];
      `OFS_PRIORITY_4:
        rd_data[15:0] = prio_word[4];
      `OFS_SRC_ENABLE:
        rd_data[`SRC_EN_W-1:0] = src_enable_ff;
      `OFS_DEBUG_PRIORITY:
        rd_data[`PRIO_W-1:0] = prio[`DEBUG_SLOT];
      `OFS_STATUS:
        rd_data[`SRC_NUM-1:0] = status_ff;
      `OFS_MASK:
        rd_data[`SRC_NUM-1:0] = mask_ff;
      `OFS_ACTIVE:
      begin
        rd_data[`PRIO_W-1:0] = irq_level_o;
        rd_data[`ACTIVE_ID_LSB +: `SRC_ID_W] = irq_id_o;
        rd_data[`ACTIVE_IRQ_BIT] = irq_o;
      end
      // unmapped: zero data and an error code
      default:
        rd_err = 1'b1;
    endcase
  end

endmodule

// *** src_model.sv ***
// peripheral request sources: one-cycle level requests on command
`timescale 1ns/1ps
module src_model
  import irq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire src_vec_t fire_i,
  output src_vec_t req_o
);
  // registered so requests change just after an edge, like a real source
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      req_o <= '0;
    else
      req_o <= fire_i;
  end
endmodule

// *** irq_regs_props.sv ***
// assertions on bus handshakes and interrupt outputs of the register bank
`timescale 1ns/1ps
module irq_regs_props
  import irq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic [1:0] bresp_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire data_t rdata_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic irq_o,
  input wire prio_t irq_level_o,
  input wire src_id_t irq_id_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  write_answer_a: assert property (!bvalid_o && awvalid_i && awready_o && wvalid_i && wready_o
    |-> ##2 bvalid_o) else $error("write not answered in two cycles");
  aw_block_a: assert property (!bvalid_o && awvalid_i && awready_o |=> !awready_o)
    else $error("address taken twice");
  resp_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped early");
  resp_code_a: assert property (bvalid_o |-> bresp_o == 2'b00 || bresp_o == 2'b10)
    else $error("bad write response code");
  read_answer_a: assert property (arvalid_i && arready_o |-> ##2 rvalid_o)
    else $error("read not answered in two cycles");
  read_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped early");
  read_release_a: assert property (rvalid_o && rready_i |=> !rvalid_o && arready_o)
    else $error("read not released");
  irq_level_a: assert property (irq_o |-> irq_level_o != 3'h0)
    else $error("interrupt with level zero");
  irq_id_a: assert property (irq_o |-> irq_id_o != 5'h0c && irq_id_o <= 5'h14)
    else $error("interrupt from reserved source");
  idle_id_a: assert property (irq_level_o == 3'h0 |-> irq_id_o == 5'h00)
    else $error("id without level");
endmodule
bind irq_enable_priority_regs irq_regs_props irq_regs_props_i (.mclk_i, .arst_n_i, .awvalid_i,
  .awready_o, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .arvalid_i, .arready_o,
  .rdata_o, .rvalid_o, .rready_i, .irq_o, .irq_level_o, .irq_id_o);

// *** testbench.sv ***
// register bank test: bus tasks, request pulses, expected values
`timescale 1ns/1ps
`include "irq_defines.svh"
module testbench
  import irq_pkg::*;
  ;
  logic mclk_i = 0;
  logic arst_n_i = 0;
  addr_t awaddr_i = '0;
  addr_t araddr_i = '0;
  logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  logic [1:0] bresp_o, rresp_o, r;
  data_t wdata_i = '0;
  strb_t wstrb_i = 4'hf;
  data_t rdata_o, d;
  src_vec_t fire = '0;
  src_vec_t req;
  prio_t irq_level_o;
  src_id_t irq_id_o;
  int fail_count = 0;
  int checks = 0;
  src_model src_model_i (.mclk_i, .arst_n_i, .fire_i(fire), .req_o(req));
  irq_enable_priority_regs irq_enable_priority_regs_i (.mclk_i, .arst_n_i, .awaddr_i,
    .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o,
    .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
    .rready_i, .src_req_i(req), .irq_o, .irq_level_o, .irq_id_o);
  initial
    forever #25 mclk_i = ~mclk_i;
  task automatic cmp_data(input data_t g, input data_t e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    cmp_data({30'h0, g}, {30'h0, e});
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 50)
    begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic wr(input addr_t a, input data_t v);
    int n;
    n = 0;
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      n++;
      if (awvalid_i && awready_o)
        awvalid_i <= 1'b0;
      if (wvalid_i && wready_o)
        wvalid_i <= 1'b0;
    end while (!bvalid_o && n < 50);
    r = bresp_o;
    bready_i <= 1'b0;
    // idle edge so the next call never re-raises in this step
    @(posedge mclk_i);
    hang(n);
  endtask
  task automatic rd(input addr_t a);
    int n;
    n = 0;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      n++;
      if (arvalid_i && arready_o)
        arvalid_i <= 1'b0;
    end while (!rvalid_o && n < 50);
    r = rresp_o;
    d = rdata_o;
    rready_i <= 1'b0;
    @(posedge mclk_i);
    hang(n);
  endtask
  task automatic wr_ok(input addr_t a, input data_t v);
    wr(a, v);
    cmp_resp(r, `RESP_OKAY);
  endtask
  task automatic rd_chk(input addr_t a, input data_t e);
    rd(a);
    cmp_resp(r, `RESP_OKAY);
    cmp_data(d, e);
  endtask
  // active register and the output ports must agree with the same figure
  task automatic act_chk(input int id, input int lvl);
    data_t e;
    e = lvl == 0 ? 32'h0 : data_t'(32'h8000 | (id << 8) | lvl);
    rd_chk(`OFS_ACTIVE, e);
    cmp_data({16'h0, irq_o, 2'h0, irq_id_o, 5'h0, irq_level_o}, e);
  endtask
  // one-cycle request, then time for status and arbitration to settle
  task automatic pulse(input src_vec_t v);
    fire <= v;
    @(posedge mclk_i);
    fire <= '0;
    repeat (4) @(posedge mclk_i);
  endtask
  function automatic addr_t pa(input int k);
    return addr_t'(`OFS_PRIORITY_0 + 4 * k);
  endfunction
  initial
  begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd_chk(`OFS_ENABLE_7, 32'h0);
    rd_chk(`OFS_DEBUG_PRIORITY, 32'h4);
    wr_ok(`OFS_ENABLE_7, '1);
    rd_chk(`OFS_ENABLE_7, 32'h20);
    for (int k = 0; k < 5; k++)
    begin
      rd_chk(pa(k), k == 3 ? 32'h0444 : 32'h4444);
      wr_ok(pa(k), '1);
      rd_chk(pa(k), k == 3 ? 32'h0777 : 32'h7777);
    end
    wr_ok(`OFS_SRC_ENABLE, 32'hfffff);
    rd_chk(`OFS_SRC_ENABLE, 32'hfefff);
    wr_ok(`OFS_MASK, 32'h1fffff);
    rd_chk(`OFS_MASK, 32'h1fefff);
    for (int k = 0; k < 5; k++)
    begin
      wr_ok(pa(k), 32'h7531);
      pulse(src_vec_t'(32'hf << (4 * k)));
      // slot 12 is reserved, so dma1 leads register 3
      act_chk(k == 3 ? 13 : 4 * k, k == 3 ? 5 : 7);
      wr_ok(`OFS_STATUS, 32'h3 << (4 * k));
      act_chk(4 * k + 2, 3);
      wr_ok(`OFS_STATUS, 32'h4 << (4 * k));
      act_chk(4 * k + 3, 1);
      wr_ok(`OFS_STATUS, 32'h8 << (4 * k));
      act_chk(0, 0);
    end
    // lane 0 only: the two upper fields keep their levels
    wstrb_i <= 4'h1;
    wr_ok(pa(1), 32'h0);
    wstrb_i <= 4'hf;
    rd_chk(pa(1), 32'h7500);
    wr_ok(pa(0), 32'h0);
    pulse(src_vec_t'(32'hf));
    act_chk(0, 0);
    wr_ok(`OFS_SRC_ENABLE, 32'h0);
    pulse(src_vec_t'(32'hf0));
    act_chk(0, 0);
    wr_ok(`OFS_ENABLE_7, 32'h0);
    pulse(src_vec_t'(32'h100000));
    act_chk(0, 0);
    wr_ok(`OFS_ENABLE_7, 32'h20);
    pulse(src_vec_t'(32'h100000));
    act_chk(20, 4);
    wr_ok(`OFS_ACTIVE, '1);
    act_chk(20, 4);
    wr_ok(`OFS_MASK, 32'h0);
    @(posedge mclk_i);
    cmp_data({31'h0, irq_o}, 32'h0);
    wr_ok(`OFS_STATUS, 32'h100000);
    rd_chk(`OFS_STATUS, 32'h0);
    wr(8'h40, '1);
    cmp_resp(r, `RESP_SLVERR);
    rd(8'h40);
    cmp_resp(r, `RESP_SLVERR);
    cmp_data(d, 32'h0);
    conclude();
  end
endmodule
